/* qsq_sequencer.sv */
// module: quad supply up/down sequencer with apb control and status
//
// Functional notes
// - four rail compliance inputs feed the sequencing state machine.
// - rising up edge in wait-start begins power-up.
// - falling down edge in power-up-done begins power-down.
// - reduced variant uses one combined pin for both directions.
// - internal fault pulls the fault line low and enters set-fault.
// - fault line pulled low by a peer enters set-fault.
// - after up edge, wait delay a then raise enable a.
// - once rail n-1 compliant, wait delay n then raise enable n.
// - power-down drops enable d at once.
// - power-down: after enable n low, wait delay n, drop enable n-1.
// - sequence-complete stays high until delay a expires after enable a low.
// - rail must comply before compliance window expires, else set-fault.
// - sequence-complete rises when power-up completes, full variant only.
// - any fault drives sequence-complete low.
// - power-good is the AND of all four compliance inputs.
// - reduced variant raises enable a right after the combined rising edge.
// - during reset every enable, power-good and sequence-complete are low.
// - start in set-fault, hold time, then clear-fault, left while up low.
// - down falling edge in wait-start or power-up is a fault.
// - in power-up-done undervoltage, up rise or fault line low faults.
// - during power-up any compliant enabled rail dropping faults.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module qsq_sequencer
    import qsq_pkg::*;
#(
    parameter logic [15:0] FAULT_HOLD_CYC = QSQ_FAULT_HOLD_CYC
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rail_sense_a_i,
    input wire logic rail_sense_b_i,
    input wire logic rail_sense_c_i,
    input wire logic rail_sense_d_i,
    input wire logic up_i,
    input wire logic down_n_i,
    input wire logic up_down_i,
    input wire logic fault_line_i,
    output logic fault_line_o,
    output logic fault_line_oe_o,
    input wire logic step_delay_a_done_i,
    input wire logic step_delay_b_done_i,
    input wire logic step_delay_c_done_i,
    input wire logic step_delay_d_done_i,
    input wire logic compliance_window_done_i,
    output logic step_delay_a_start_o,
    output logic step_delay_b_start_o,
    output logic step_delay_c_start_o,
    output logic step_delay_d_start_o,
    output logic compliance_window_start_o,
    output logic rail_enable_a_o,
    output logic rail_enable_b_o,
    output logic rail_enable_c_o,
    output logic rail_enable_d_o,
    output logic sequence_complete_o,
    output logic all_rails_good_o
);
    // mask of rail indices strictly below n
    function automatic logic [3:0] below_mask(input logic [1:0] n);
        below_mask = 4'((5'h01 << n) - 5'h01);
    endfunction

    // apb address decode
    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        if (a == QSQ_CTRL_ADDR) begin
            reg_sel = QSQ_SEL_CTRL;
        end else if (a == QSQ_STAT_ADDR) begin
            reg_sel = QSQ_SEL_STAT;
        end else begin
            reg_sel = QSQ_SEL_NONE;
        end
    endfunction

    qsq_state_e state_q;
    logic [1:0] idx_q;
    logic [3:0] en_q;
    logic [3:0] dly_start_q;
    logic win_start_q;
    logic sequence_complete_q;
    logic pg_q;
    logic fault_oe_q;
    logic fault_lvl_q;
    logic [15:0] hold_q;
    logic [2:0] blank_q;
    logic reduced_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [QSQ_SYNC_W-1:0] sync_s;
    logic [3:0] sense_s;
    logic [3:0] done_s;
    logic up_s, dn_s, cmb_s, flt_s, win_s;
    logic up_lvl, up_p_q, dn_p_q, cmb_p_q, win_p_q;
    logic [3:0] done_p_q;
    logic up_rise, dn_fall, win_exp, dly_exp, ext_flt;
    logic go_fault, up_go, dly_hit, chk_ok, dn_go, dn_hit, hold_done, clr_exit;
    logic [31:0] ctrl_w;
    logic [31:0] stat_w;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    qsq_sync #(.W(QSQ_SYNC_W)) u_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({compliance_window_done_i, step_delay_d_done_i, step_delay_c_done_i,
                step_delay_b_done_i, step_delay_a_done_i, fault_line_i, up_down_i,
                down_n_i, up_i, rail_sense_d_i, rail_sense_c_i, rail_sense_b_i,
                rail_sense_a_i}),
        .level_o(sync_s)
    );

    // unpack synchronised levels
    assign sense_s = sync_s[3:0];
    assign up_s = sync_s[4];
    assign dn_s = sync_s[5];
    assign cmb_s = sync_s[6];
    assign flt_s = sync_s[7];
    assign done_s = sync_s[11:8];
    assign win_s = sync_s[12];

    // up level per variant, used for leaving clear-fault
    // edges below are kept per pin so a variant switch cannot fake one
    assign up_lvl = reduced_q ? cmb_s : up_s;

    // previous values for edges
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            up_p_q <= 1'b0;
            dn_p_q <= 1'b0;
            cmb_p_q <= 1'b0;
            win_p_q <= 1'b0;
            done_p_q <= 4'h0;
        end else begin
            up_p_q <= up_s;
            dn_p_q <= dn_s;
            cmb_p_q <= cmb_s;
            win_p_q <= win_s;
            done_p_q <= done_s;
        end
    end

    // edges; expiry is the rising edge of a generator's done level
    assign up_rise = reduced_q ? (cmb_s & ~cmb_p_q) : (up_s & ~up_p_q);
    assign dn_fall = reduced_q ? (~cmb_s & cmb_p_q) : (~dn_s & dn_p_q);
    assign win_exp = win_s & ~win_p_q;
    assign dly_exp = done_s[idx_q] & ~done_p_q[idx_q];
    assign ext_flt = ~flt_s & (blank_q == 3'h0);

    ////////////////////////////////////////////////////////////////////////////
    // sequencing decisions
    always_comb begin
        go_fault = 1'b0;
        unique case (state_q)
            st_wait_start: go_fault = dn_fall | ext_flt;
            st_up_delay: go_fault = dn_fall | ext_flt | |(~sense_s & below_mask(idx_q));
            st_up_check: go_fault = dn_fall | ext_flt | |(~sense_s & below_mask(idx_q))
                                    | (win_exp & ~sense_s[idx_q]);
            st_up_done: go_fault = ~&sense_s | (up_rise & ~reduced_q) | ext_flt;
            st_down_delay: go_fault = ext_flt;
            st_set_fault, st_clear_fault: go_fault = 1'b0;
        endcase
    end

    // progress events, each valid only in its state
    assign up_go = (state_q == st_wait_start) & up_rise & ~go_fault;
    assign dly_hit = (state_q == st_up_delay) & dly_exp & ~go_fault;
    assign chk_ok = (state_q == st_up_check) & sense_s[idx_q] & ~go_fault;
    assign dn_go = (state_q == st_up_done) & dn_fall & ~go_fault;
    assign dn_hit = (state_q == st_down_delay) & dly_exp & ~go_fault;
    assign hold_done = (state_q == st_set_fault) & (hold_q == FAULT_HOLD_CYC - 16'h0001);
    assign clr_exit = (state_q == st_clear_fault) & ~up_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= st_set_fault;
        end else if (go_fault) begin
            state_q <= st_set_fault;
        end else begin
            unique case (state_q)
                st_set_fault: if (hold_done) state_q <= st_clear_fault;
                st_clear_fault: if (clr_exit) state_q <= st_wait_start;
                st_wait_start: if (up_go) state_q <= reduced_q ? st_up_check : st_up_delay;
                st_up_delay: if (dly_hit) state_q <= st_up_check;
                st_up_check: if (chk_ok) state_q <= (idx_q == 2'h3) ? st_up_done : st_up_delay;
                st_up_done: if (dn_go) state_q <= st_down_delay;
                st_down_delay: begin
                    if (dn_hit && (idx_q == 2'h0 || (idx_q == 2'h1 && reduced_q))) begin
                        state_q <= st_wait_start;
                    end
                end
            endcase
        end
    end

    // rail index walks up on power-up, down on power-down
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idx_q <= 2'h0;
        end else if (up_go) begin
            idx_q <= 2'h0;
        end else if (chk_ok && idx_q != 2'h3) begin
            idx_q <= idx_q + 2'h1;
        end else if (dn_go) begin
            idx_q <= 2'h3;
        end else if (dn_hit && idx_q != 2'h0) begin
            idx_q <= idx_q - 2'h1;
        end
    end

    // rail enables
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_q <= 4'h0;
        end else if (go_fault) begin
            en_q <= 4'h0;
        end else if (up_go && reduced_q) begin
            en_q[0] <= 1'b1;
        end else if (dly_hit) begin
            en_q[idx_q] <= 1'b1;
        end else if (dn_go) begin
            en_q[3] <= 1'b0;
        end else if (dn_hit && idx_q != 2'h0) begin
            en_q[idx_q - 2'h1] <= 1'b0;
        end
    end

    // one-cycle start strobes to the delay generators
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dly_start_q <= 4'h0;
            win_start_q <= 1'b0;
        end else begin
            dly_start_q <= 4'h0;
            win_start_q <= dly_hit | (up_go & reduced_q);
            if (up_go && !reduced_q) begin
                dly_start_q[0] <= 1'b1;
            end else if (chk_ok && idx_q != 2'h3) begin
                dly_start_q[idx_q + 2'h1] <= 1'b1;
            end else if (dn_go) begin
                dly_start_q[3] <= 1'b1;
            end else if (dn_hit && idx_q != 2'h0 && !(idx_q == 2'h1 && reduced_q)) begin
                dly_start_q[idx_q - 2'h1] <= 1'b1;
            end
        end
    end

    // sequence complete
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sequence_complete_q <= 1'b0;
        end else if (go_fault) begin
            sequence_complete_q <= 1'b0;
        end else if (chk_ok && idx_q == 2'h3 && !reduced_q) begin
            sequence_complete_q <= 1'b1;
        end else if (dn_hit && idx_q == 2'h0) begin
            sequence_complete_q <= 1'b0;
        end
    end

    // power good from the four compliance levels
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pg_q <= 1'b0;
        end else begin
            pg_q <= &sense_s;
        end
    end

    // fault line pull-down, hold timer, and blanking of our own pull-down
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fault_oe_q <= 1'b1;
            fault_lvl_q <= 1'b0;
            hold_q <= 16'h0000;
            blank_q <= QSQ_FLT_BLANK_CYC;
        end else begin
            fault_lvl_q <= 1'b0;
            hold_q <= (state_q == st_set_fault && !hold_done) ? hold_q + 16'h0001 : 16'h0000;
            if (go_fault) begin
                fault_oe_q <= 1'b1;
            end else if (clr_exit) begin
                fault_oe_q <= 1'b0;
            end
            blank_q <= fault_oe_q ? QSQ_FLT_BLANK_CYC
                     : (blank_q == 3'h0) ? 3'h0 : blank_q - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one access cycle, error on unmapped address
    always_comb begin
        ctrl_w = 32'h0;
        ctrl_w[QSQ_CTRL_REDUCED_BIT] = reduced_q;
        stat_w = 32'h0;
        stat_w[QSQ_ST_STATE_LSB +: 3] = state_q;
        stat_w[QSQ_ST_EN_LSB +: 4] = en_q;
        stat_w[QSQ_ST_SENSE_LSB +: 4] = sense_s;
        stat_w[QSQ_ST_DONE_BIT] = sequence_complete_q;
        stat_w[QSQ_ST_PG_BIT] = pg_q;
        stat_w[QSQ_ST_FLT_BIT] = fault_oe_q;
        stat_w[QSQ_ST_RED_BIT] = reduced_q;
    end

    // answer prepared in the setup cycle
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (psel_i && !penable_i) begin
            pready_q <= 1'b1;
            pslverr_q <= (reg_sel(paddr_i) == QSQ_SEL_NONE);
            prdata_q <= pwrite_i ? 32'h0 : (reg_sel(paddr_i) == QSQ_SEL_CTRL) ? ctrl_w
                      : (reg_sel(paddr_i) == QSQ_SEL_STAT) ? stat_w : 32'h0;
        end else begin
            pready_q <= 1'b0;
        end
    end

    // variant select, written at the completing access edge
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reduced_q <= QSQ_CTRL_REDUCED_RST;
        end else if (psel_i && penable_i && pready_q && pwrite_i && pstrb_i[0]
                     && reg_sel(paddr_i) == QSQ_SEL_CTRL) begin
            reduced_q <= pwdata_i[QSQ_CTRL_REDUCED_BIT];
        end
    end

    // outputs straight from flops
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign fault_line_o = fault_lvl_q;
    assign fault_line_oe_o = fault_oe_q;
    assign step_delay_a_start_o = dly_start_q[0];
    assign step_delay_b_start_o = dly_start_q[1];
    assign step_delay_c_start_o = dly_start_q[2];
    assign step_delay_d_start_o = dly_start_q[3];
    assign compliance_window_start_o = win_start_q;
    assign rail_enable_a_o = en_q[0];
    assign rail_enable_b_o = en_q[1];
    assign rail_enable_c_o = en_q[2];
    assign rail_enable_d_o = en_q[3];
    assign sequence_complete_o = sequence_complete_q;
    assign all_rails_good_o = pg_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_up_starts_delay: assert property ((state_q == st_wait_start) && up_rise && !go_fault && !reduced_q
        |=> step_delay_a_start_o && state_q == st_up_delay && !rail_enable_a_o)
        else $error("up edge did not start delay a");
    a_down_drops_d: assert property (dn_go |=> !rail_enable_d_o ##1 !step_delay_d_start_o)
        else $error("enable d not dropped at down request");
    a_reduced_a_on: assert property ((state_q == st_wait_start) && up_rise && !go_fault && reduced_q
        |=> rail_enable_a_o && compliance_window_start_o)
        else $error("reduced variant did not raise enable a");
    a_window_fault: assert property ((state_q == st_up_check) && win_exp && !sense_s[idx_q]
        |=> state_q == st_set_fault ##1 fault_line_oe_o && en_q == 4'h0)
        else $error("window expiry without compliance not faulted");
    a_fault_clears: assert property ($rose(state_q == st_set_fault)
        |-> en_q == 4'h0 && !sequence_complete_o && fault_line_oe_o)
        else $error("set-fault left enables or done high");
    a_ext_fault_in: assert property ((state_q == st_up_done) && ext_flt |=> state_q == st_set_fault)
        else $error("external fault ignored in power-up-done");
    a_down_edge_fault: assert property ((state_q == st_wait_start) && dn_fall |=> state_q == st_set_fault)
        else $error("down edge in wait-start not faulted");
    a_enable_order: assert property ($rose(rail_enable_b_o) |-> rail_enable_a_o && $past(sense_s[0], 2))
        else $error("enable b rose out of order");
    a_pgood_and: assert property (all_rails_good_o == $past(&sense_s))
        else $error("power good not the and of senses");
    a_clear_holds: assert property ((state_q == st_clear_fault) && up_lvl
        |=> state_q == st_clear_fault && fault_line_oe_o)
        else $error("clear-fault left with up high");
    a_done_falls: assert property (dn_hit && idx_q == 2'h0 |=> !sequence_complete_o && !rail_enable_a_o)
        else $error("sequence complete not dropped after delay a");

    c_up_done: cover property (state_q == st_up_check ##1 state_q == st_up_done);
    c_down_end: cover property (state_q == st_down_delay ##1 state_q == st_wait_start);
    c_win_fault: cover property ((state_q == st_up_check) && win_exp && !sense_s[idx_q]);
    c_ext_fault: cover property ((state_q == st_up_done) && ext_flt);
endmodule // qsq_sequencer
`default_nettype wire

/* qsq_pkg.sv */
// package: constants, register map and state type of the quad supply sequencer
package qsq_pkg;
    // clock and fault hold time
    localparam int QSQ_CLK_PERIOD_PS = 4000;
    localparam int QSQ_FAULT_HOLD_US = 35;
    localparam logic [15:0] QSQ_FAULT_HOLD_CYC =
        16'((QSQ_FAULT_HOLD_US * 1000000 + QSQ_CLK_PERIOD_PS - 1) / QSQ_CLK_PERIOD_PS);
    // cycles the sensed fault line is ignored after our own pull-down lets go
    localparam logic [2:0] QSQ_FLT_BLANK_CYC = 3'h6;
    // synchronised pins: 4 senses, up, down, combined, fault, 4 step expiries, window expiry
    localparam int QSQ_SYNC_W = 13;
    // apb register map
    localparam logic [7:0] QSQ_CTRL_ADDR = 8'h00;
    localparam logic [7:0] QSQ_STAT_ADDR = 8'h04;
    localparam logic [1:0] QSQ_SEL_NONE = 2'h0;
    localparam logic [1:0] QSQ_SEL_CTRL = 2'h1;
    localparam logic [1:0] QSQ_SEL_STAT = 2'h2;
    localparam int QSQ_CTRL_REDUCED_BIT = 0;
    localparam logic QSQ_CTRL_REDUCED_RST = 1'b0;
    // status word fields
    localparam int QSQ_ST_STATE_LSB = 0;
    localparam int QSQ_ST_EN_LSB = 4;
    localparam int QSQ_ST_SENSE_LSB = 8;
    localparam int QSQ_ST_DONE_BIT = 12;
    localparam int QSQ_ST_PG_BIT = 13;
    localparam int QSQ_ST_FLT_BIT = 14;
    localparam int QSQ_ST_RED_BIT = 15;
    // sequencing states
    typedef enum logic [2:0] {
        st_set_fault,
        st_clear_fault,
        st_wait_start,
        st_up_delay,
        st_up_check,
        st_up_done,
        st_down_delay
    } qsq_state_e;
endpackage

/* qsq_sync.sv */
// module: three-flop pin synchroniser that accepts a change once two stages agree
`timescale 1ns/1ps
`default_nettype none
module qsq_sync #(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;
    logic [W-1:0] ff3_q;
    logic [W-1:0] lvl_q;

    // shift chain; the first stage feeds only the second
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ff1_q <= '0;
            ff2_q <= '0;
            ff3_q <= '0;
        end else begin
            ff1_q <= pin_i;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
        end
    end

    // update only bits whose second and third stages agree
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= (ff2_q & ~(ff2_q ^ ff3_q)) | (lvl_q & (ff2_q ^ ff3_q));
        end
    end

    assign level_o = lvl_q;
endmodule // qsq_sync
`default_nettype wire

/* qsq_rail_model.sv */
// regulators and delay generators around the quad supply sequencer
`timescale 1ns/1ps
`default_nettype none
module qsq_rail_model (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic slow_i,
    input wire logic [3:0] enable_i,
    input wire logic [4:0] start_i,
    input wire logic [3:0] sag_i,
    output logic [3:0] sense_o,
    output logic [4:0] done_o
);
    localparam int STEP_CYC = 20;
    localparam int WIN_CYC = 60;
    logic [7:0] cnt_q [5];
    logic [3:0] ramp_q [8];
    ////////////////////////////////////////////////////////////////
    // timers: done rises a set time after start, cleared on restart
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_o <= 5'h00;
            for (int i = 0; i < 5; i++) begin
                cnt_q[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (start_i[i]) begin
                    cnt_q[i] <= (i == 4) ? 8'(WIN_CYC) : 8'(slow_i ? 2 * STEP_CYC : STEP_CYC);
                    done_o[i] <= 1'b0;
                end else if (cnt_q[i] != 8'h00) begin
                    cnt_q[i] <= cnt_q[i] - 8'h01;
                    done_o[i] <= (cnt_q[i] == 8'h01);
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // regulator ramp: rail crosses its threshold 8 cycles after enable
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 8; i++) begin
                ramp_q[i] <= 4'h0;
            end
        end else begin
            ramp_q[0] <= enable_i;
            for (int i = 1; i < 8; i++) begin
                ramp_q[i] <= ramp_q[i-1];
            end
        end
    end
    assign sense_o = ramp_q[7] & ~sag_i;
endmodule // qsq_rail_model
`default_nettype wire

/* testbench.sv */
// self-checking bench for the quad supply sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import qsq_pkg::*;
    logic clock_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, up, down_n, up_down;
    logic peer_pull, fault_oe, fault_w, seq, pg, slow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] sense, en, sag;
    logic [4:0] start, done;
    logic [5:0] obs;
    logic e;
    int n_fail, n_tests, n_start_a, w_cyc, k;
    assign fault_w = ~(fault_oe | peer_pull);
    assign obs = {fault_oe, seq, en};
    qsq_sequencer #(.FAULT_HOLD_CYC(16'h0010)) u_qsq_sequencer (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .rail_sense_a_i(sense[0]), .rail_sense_b_i(sense[1]), .rail_sense_c_i(sense[2]),
        .rail_sense_d_i(sense[3]), .up_i(up), .down_n_i(down_n), .up_down_i(up_down),
        .fault_line_i(fault_w), .fault_line_o(), .fault_line_oe_o(fault_oe),
        .step_delay_a_done_i(done[0]), .step_delay_b_done_i(done[1]), .step_delay_c_done_i(done[2]),
        .step_delay_d_done_i(done[3]), .compliance_window_done_i(done[4]),
        .step_delay_a_start_o(start[0]), .step_delay_b_start_o(start[1]),
        .step_delay_c_start_o(start[2]), .step_delay_d_start_o(start[3]),
        .compliance_window_start_o(start[4]), .rail_enable_a_o(en[0]), .rail_enable_b_o(en[1]),
        .rail_enable_c_o(en[2]), .rail_enable_d_o(en[3]), .sequence_complete_o(seq),
        .all_rails_good_o(pg));
    qsq_rail_model u_qsq_rail_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .enable_i(en), .start_i(start), .sag_i(sag), .sense_o(sense), .done_o(done));
    ////////////////////////////////////////////////////////////////
    // comparison, verdict, bus and waiting helpers
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            n++;
        end
        check("pready", 32'(pready), 32'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_obs(input logic [5:0] want);
        w_cyc = 0;
        while (obs !== want && w_cyc < 3000) begin
            @(negedge clock_i);
            w_cyc++;
        end
        check("fault oe, done, enables", 32'(obs), 32'(want));
    endtask
    task automatic power_up;
        @(posedge clock_i);
        up <= 1'b1;
        wait_obs(6'h1f);
        check("power good", 32'(pg), 32'h1);
        @(posedge clock_i);
        up <= 1'b0;
    endtask
    task automatic step(input logic [3:0] s, input logic u, input logic dn, input logic p);
        @(posedge clock_i);
        sag <= s;
        up <= u;
        down_n <= dn;
        peer_pull <= p;
    endtask
    ////////////////////////////////////////////////////////////////
    // clock, start pulse counter, enable order monitor, watchdog
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    always @(negedge clock_i) begin
        if (start[0] === 1'b1) n_start_a++;
        if (!(en inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})) check("enable order", 32'(en), 32'hf);
    end
    initial begin
        repeat (60000) @(posedge clock_i);
        n_fail++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, up, up_down, peer_pull, slow, sag} = '0;
        {n_fail, n_tests, n_start_a} = '0;
        down_n = 1'b1;
        sys_rst_i = 1'b1;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        check("reset outputs", 32'({obs, pg}), 32'h40);
        @(posedge clock_i);
        sys_rst_i <= 1'b0;
        wait_obs(6'h00);
        check("hold long enough", 32'(w_cyc >= 16), 32'h1);
        apb(1'b0, QSQ_STAT_ADDR, 32'h0);
        check("state", 32'(r[2:0]), 32'h2);
        apb(1'b0, 8'h08, 32'h0);
        check("unmapped error", 32'(e), 32'h1);
        apb(1'b0, QSQ_CTRL_ADDR, 32'h0);
        check("ctrl reset", r, 32'h0);
        step(4'h0, 1'b1, 1'b1, 1'b0);
        step(4'h0, 1'b0, 1'b1, 1'b0);
        repeat (40) @(posedge clock_i);
        check("glitch start", 32'(n_start_a), 32'h0);
        power_up();
        check("delay a starts", 32'(n_start_a), 32'h1);
        step(4'h0, 1'b0, 1'b0, 1'b0);
        wait_obs(6'h17);
        wait_obs(6'h10);
        wait_obs(6'h00);
        step(4'h0, 1'b0, 1'b1, 1'b0);
        // fault sources: undervoltage, peer pull, missed window, early down edge
        for (k = 0; k < 4; k++) begin
            if (k < 2) power_up();
            if (k == 2) step(4'h1, 1'b1, 1'b1, 1'b0);
            if (k == 2) wait_obs(6'h01);
            step(k == 0 ? 4'h2 : (k == 2 ? 4'h1 : 4'h0), 1'b0, k != 3, k == 1);
            wait_obs(6'h20);
            step(4'h0, 1'b0, 1'b1, 1'b0);
            wait_obs(6'h00);
        end
        apb(1'b1, QSQ_CTRL_ADDR, 32'h1);
        apb(1'b0, QSQ_CTRL_ADDR, 32'h0);
        check("ctrl reduced", r, 32'h1);
        k = n_start_a;
        slow <= 1'b1;
        @(posedge clock_i);
        up_down <= 1'b1;
        wait_obs(6'h01);
        wait_obs(6'h0f);
        repeat (40) @(posedge clock_i);
        check("reduced no done", 32'({obs, pg}), 32'h1f);
        check("no delay a", 32'(n_start_a - k), 32'h0);
        @(posedge clock_i);
        up_down <= 1'b0;
        wait_obs(6'h00);
        repeat (20) @(posedge clock_i);
        check("power good low", 32'(pg), 32'h0);
        conclude();
    end
endmodule // testbench
`default_nettype wire
